// file: pkg/pac_pkg.sv
package pac_pkg;
    // ==================== bus map
    localparam int unsigned PAC_AW = 12;
    localparam logic [11:0] PAC_CTRL_OFF = 12'h000;
    localparam logic [11:0] PAC_STATUS_OFF = 12'h004;
    localparam logic [11:0] PAC_FADDR_OFF = 12'h008;
    // region n sits at (n + 1) * 16: base, limit, attributes
    localparam logic [1:0] PAC_RGN_BASE_W = 2'h0;
    localparam logic [1:0] PAC_RGN_LIMIT_W = 2'h1;
    localparam logic [1:0] PAC_RGN_ATTR_W = 2'h2;
    // ==================== field positions
    localparam int unsigned PAC_CTRL_EN = 0;
    localparam int unsigned PAC_CTRL_DEFMAP = 1;
    localparam int unsigned PAC_ST_DFAULT = 0;
    localparam int unsigned PAC_ST_IFAULT = 1;
    localparam int unsigned PAC_ST_UNPRIV = 2;
    localparam int unsigned PAC_AT_RD = 0;
    localparam int unsigned PAC_AT_WR = 2;
    localparam int unsigned PAC_AT_EXEC_NEVER = 4;
    localparam int unsigned PAC_AT_EN = 5;
    localparam int unsigned PAC_AT_SH = 6;
    localparam int unsigned PAC_AT_SO = 7;
    localparam int unsigned PAC_AT_W = 8;
    // ==================== access levels
    localparam logic [1:0] PAC_LVL_NONE = 2'h0;
    localparam logic [1:0] PAC_LVL_PRIV = 2'h1;
    localparam logic [1:0] PAC_LVL_ALL = 2'h2;
    // ==================== reset values
    localparam logic [1:0] PAC_CTRL_RST = 2'h0;
    localparam logic [2:0] PAC_STATUS_RST = 3'h0;
    localparam logic [31:0] PAC_WORD_RST = 32'h0000_0000;
    localparam logic [7:0] PAC_ATTR_RST = 8'h00;
endpackage

// file: src/pac_checker.sv
// Added by the designer: the address map and the APB slave port.
`timescale 1ns/1ns
// Function
// - regions grant data access to nobody, privileged only, or everybody.
// - reads and writes use separate rights fields of the region.
// - the reserved level code is not supported and denies access.
// - privileged execution with ordinary loads and stores is a privileged access.
// - unprivileged-only mode or an unprivileged-variant load/store gives an unprivileged access.
// - a data access the region rights forbid raises a fault.
// - unprivileged access to a privileged-only region raises memory_management_fault.
// - regions grant execution to nobody, privileged only, or everybody.
// - execute_never_flag forbids fetching from the region regardless of read rights.
// - execute permission is read rights at fetch privilege with execute-never clear.
// - a forbidden fetch raises memory_management_fault.
// - data privilege checks apply only while protection is enabled.
// - the default map still blocks execution while protection is disabled.
// - ordering marks go only to explicit accesses, never to fetches.
// - store-exclusive status and table-branch reads are treated as reads.
// - exclusives pass to shareable and non-shareable regions alike.
// - completion needs global observation and observation by instruction fetches.
// - strongly-ordered peripheral access is observed only once side effects can trigger.
module pac_checker #(
    parameter int unsigned NUM_REGIONS = 4,
    parameter logic [31:0] DEFMAP_NOEXEC_BASE = 32'hF000_0000
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [pac_pkg::PAC_AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic d_valid,
    input wire logic [31:0] d_addr,
    input wire logic d_write,
    input wire logic d_priv_exec,
    input wire logic d_mode_unpriv_only,
    input wire logic d_unpriv_variant,
    input wire logic d_excl_status,
    input wire logic d_table_branch,
    input wire logic d_exclusive,
    output logic d_fwd_valid,
    output logic d_fwd_read,
    output logic d_fwd_excl_shared,
    output logic d_fwd_ordered,
    input wire logic i_valid,
    input wire logic [31:0] i_addr,
    input wire logic i_priv,
    output logic i_fwd_valid,
    input wire logic m_observed,
    input wire logic m_fetch_observed,
    input wire logic m_side_effect_ready,
    output logic d_complete,
    output logic memory_management_fault
);
    import pac_pkg::*;

    // ==================== registers
    logic [1:0] ctrl_reg;
    logic [2:0] status_reg;
    logic [2:0] status_next;
    logic [31:0] faddr_reg;
    logic [31:0] base_reg [NUM_REGIONS];
    logic [31:0] limit_reg [NUM_REGIONS];
    logic [PAC_AT_W-1:0] attr_reg [NUM_REGIONS];
    logic [31:0] rdata_next;
    logic d_fault_reg;
    logic i_fault_reg;
    logic unpriv_fault_reg;
    logic so_pend_reg;

    // ==================== bus decode
    wire logic wr_en = psel & penable & pwrite;
    wire logic setup = psel & ~penable;
    wire logic [7:0] rgn_slot = paddr[11:4];
    wire logic [7:0] rgn_idx = rgn_slot - 8'h01;
    wire logic rgn_sel = (rgn_slot != 8'h00) && (rgn_idx < 8'(NUM_REGIONS))
        && (paddr[3:2] != 2'h3) && (paddr[1:0] == 2'h0);
    wire logic ctrl_sel = paddr == PAC_CTRL_OFF;
    wire logic status_sel = paddr == PAC_STATUS_OFF;
    wire logic faddr_sel = paddr == PAC_FADDR_OFF;
    wire logic mapped = ctrl_sel | status_sel | faddr_sel | rgn_sel;

    // zero wait states: every answer comes in the first access cycle
    assign pready = 1'b1;

    always_comb begin
        rdata_next = PAC_WORD_RST;
        if (ctrl_sel) begin
            rdata_next = {30'h0000_0000, ctrl_reg};
        end else if (status_sel) begin
            rdata_next = {29'h0000_0000, status_reg};
        end else if (faddr_sel) begin
            rdata_next = faddr_reg;
        end else if (rgn_sel) begin
            for (int k = 0; k < NUM_REGIONS; k++) begin
                if (rgn_idx == 8'(k)) begin
                    unique case (paddr[3:2])
                        PAC_RGN_BASE_W: rdata_next = base_reg[k];
                        PAC_RGN_LIMIT_W: rdata_next = limit_reg[k];
                        default: rdata_next = {24'h00_0000, attr_reg[k]};
                    endcase
                end
            end
        end
    end

    // read data and error are latched in the setup cycle so they leave flip-flops
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= PAC_WORD_RST;
            pslverr <= 1'b0;
        end else if (setup) begin
            prdata <= pwrite ? PAC_WORD_RST : rdata_next;
            pslverr <= ~mapped;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg <= PAC_CTRL_RST;
        end else if (wr_en && ctrl_sel) begin
            ctrl_reg <= pwdata[1:0];
        end
    end

    // ==================== region table
    logic [NUM_REGIONS-1:0] d_hit;
    logic [NUM_REGIONS-1:0] i_hit;

    for (genvar g = 0; g < NUM_REGIONS; g++) begin : g_rgn
        wire logic wr_rgn = wr_en && rgn_sel && (rgn_idx == 8'(g));
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                base_reg[g] <= PAC_WORD_RST;
                limit_reg[g] <= PAC_WORD_RST;
                attr_reg[g] <= PAC_ATTR_RST;
            end else if (wr_rgn) begin
                if (paddr[3:2] == PAC_RGN_BASE_W) begin
                    base_reg[g] <= pwdata;
                end
                if (paddr[3:2] == PAC_RGN_LIMIT_W) begin
                    limit_reg[g] <= pwdata;
                end
                if (paddr[3:2] == PAC_RGN_ATTR_W) begin
                    attr_reg[g] <= pwdata[PAC_AT_W-1:0];
                end
            end
        end
        assign d_hit[g] = attr_reg[g][PAC_AT_EN] && d_addr >= base_reg[g] && d_addr <= limit_reg[g];
        assign i_hit[g] = attr_reg[g][PAC_AT_EN] && i_addr >= base_reg[g] && i_addr <= limit_reg[g];
    end

    // overlapping regions: the highest number wins
    logic [PAC_AT_W-1:0] d_attr;
    logic [PAC_AT_W-1:0] i_attr;
    always_comb begin
        d_attr = PAC_ATTR_RST;
        i_attr = PAC_ATTR_RST;
        for (int k = 0; k < NUM_REGIONS; k++) begin
            if (d_hit[k]) begin
                d_attr = attr_reg[k];
            end
            if (i_hit[k]) begin
                i_attr = attr_reg[k];
            end
        end
    end

    function automatic logic lvl_ok(input logic [1:0] lvl, input logic unpriv);
        lvl_ok = (lvl == PAC_LVL_ALL) || (lvl == PAC_LVL_PRIV && !unpriv);
    endfunction

    // ==================== data checks
    wire logic prot_en = ctrl_reg[PAC_CTRL_EN];
    wire logic d_any = |d_hit;
    wire logic i_any = |i_hit;
    wire logic d_unpriv = d_mode_unpriv_only | d_unpriv_variant | ~d_priv_exec;
    wire logic d_is_read = ~d_write | d_excl_status | d_table_branch;
    wire logic [1:0] d_lvl = d_is_read ? d_attr[PAC_AT_RD +: 2] : d_attr[PAC_AT_WR +: 2];
    // outside every region only privileged accesses pass
    wire logic d_rights = d_any ? lvl_ok(d_lvl, d_unpriv) : ~d_unpriv;
    wire logic d_allow = ~prot_en | d_rights;
    wire logic d_bad = d_valid & ~d_allow;

    assign d_fwd_valid = d_valid & d_allow;
    assign d_fwd_read = d_is_read;
    assign d_fwd_excl_shared = d_exclusive & d_any & d_attr[PAC_AT_SH];
    // fetches never carry this mark, so they are never held behind data
    assign d_fwd_ordered = d_fwd_valid & d_any & d_attr[PAC_AT_SO];

    // ==================== fetch checks
    wire logic i_exec = ~i_attr[PAC_AT_EXEC_NEVER] & lvl_ok(i_attr[PAC_AT_RD +: 2], ~i_priv);
    wire logic defmap_noexec = ctrl_reg[PAC_CTRL_DEFMAP] && i_addr >= DEFMAP_NOEXEC_BASE;
    wire logic i_rights = i_any ? i_exec : (i_priv & ~defmap_noexec);
    wire logic i_allow = prot_en ? i_rights : ~defmap_noexec;
    wire logic i_bad = i_valid & ~i_allow;

    assign i_fwd_valid = i_valid & i_allow;

    // ==================== fault reporting
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            d_fault_reg <= 1'b0;
            i_fault_reg <= 1'b0;
            unpriv_fault_reg <= 1'b0;
        end else begin
            d_fault_reg <= d_bad;
            i_fault_reg <= i_bad;
            unpriv_fault_reg <= d_bad & d_unpriv;
        end
    end

    assign memory_management_fault = d_fault_reg | i_fault_reg;

    // write one to clear; a fault in the same cycle keeps its bit set
    wire logic [2:0] st_clr = (wr_en && status_sel) ? pwdata[2:0] : 3'h0;
    wire logic [2:0] st_set = {unpriv_fault_reg, i_fault_reg, d_fault_reg};

    always_comb begin
        status_next = (status_reg & ~st_clr) | st_set;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_reg <= PAC_STATUS_RST;
            faddr_reg <= PAC_WORD_RST;
        end else begin
            status_reg <= status_next;
            if (d_bad) begin
                faddr_reg <= d_addr;
            end else if (i_bad) begin
                faddr_reg <= i_addr;
            end
        end
    end

    // ==================== completion
    // one outstanding data access is assumed; the memory answers in order
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            so_pend_reg <= 1'b0;
        end else if (d_fwd_ordered) begin
            // a new ordered access outranks the completion of the one before it
            so_pend_reg <= 1'b1;
        end else if (d_complete) begin
            so_pend_reg <= 1'b0;
        end
    end

    assign d_complete = m_observed & m_fetch_observed & (~so_pend_reg | m_side_effect_ready);

    // ==================== checks
    property p_disabled_pass;
        @(posedge pclk) disable iff (!presetn)
        d_valid && !prot_en |-> d_fwd_valid;
    endproperty
    a_disabled_pass: assert property (p_disabled_pass) else $error("data blocked while disabled");

    property p_block_then_fault;
        @(posedge pclk) disable iff (!presetn)
        d_valid && prot_en && !d_rights |-> !d_fwd_valid ##1 memory_management_fault;
    endproperty
    a_block_then_fault: assert property (p_block_then_fault) else $error("bad data access passed");

    property p_unpriv_privonly;
        @(posedge pclk) disable iff (!presetn)
        d_valid && prot_en && d_any && d_lvl == PAC_LVL_PRIV && (d_mode_unpriv_only || !d_priv_exec)
        |=> memory_management_fault && status_next[PAC_ST_UNPRIV];
    endproperty
    a_unpriv_privonly: assert property (p_unpriv_privonly) else $error("no fault on unpriv access");

    property p_variant_unpriv;
        @(posedge pclk) disable iff (!presetn)
        d_valid && prot_en && d_any && d_lvl == PAC_LVL_PRIV && d_unpriv_variant |-> !d_fwd_valid;
    endproperty
    a_variant_unpriv: assert property (p_variant_unpriv) else $error("variant treated as privileged");

    property p_priv_pass;
        @(posedge pclk) disable iff (!presetn)
        d_valid && d_any && d_lvl == PAC_LVL_PRIV && d_priv_exec && !d_mode_unpriv_only && !d_unpriv_variant
        |-> d_fwd_valid ##1 !d_fault_reg;
    endproperty
    a_priv_pass: assert property (p_priv_pass) else $error("privileged access refused");

    property p_none_level;
        @(posedge pclk) disable iff (!presetn)
        d_valid && prot_en && d_any && d_lvl != PAC_LVL_PRIV && d_lvl != PAC_LVL_ALL |-> !d_fwd_valid;
    endproperty
    a_none_level: assert property (p_none_level) else $error("no-access region passed");

    property p_never_fetch;
        @(posedge pclk) disable iff (!presetn)
        i_valid && prot_en && i_any && i_attr[PAC_AT_EXEC_NEVER]
        |-> !i_fwd_valid ##1 i_fault_reg ##1 status_reg[PAC_ST_IFAULT];
    endproperty
    a_never_fetch: assert property (p_never_fetch) else $error("fetch from execute-never region");

    property p_priv_exec;
        @(posedge pclk) disable iff (!presetn)
        i_valid && prot_en && i_any && !i_attr[PAC_AT_EXEC_NEVER] && i_attr[PAC_AT_RD +: 2] == PAC_LVL_PRIV
        |-> i_fwd_valid == i_priv;
    endproperty
    a_priv_exec: assert property (p_priv_exec) else $error("privileged-only execute wrong");

    property p_defmap_xn;
        @(posedge pclk) disable iff (!presetn)
        i_valid && !prot_en && ctrl_reg[PAC_CTRL_DEFMAP] && i_addr >= DEFMAP_NOEXEC_BASE
        |-> !i_fwd_valid ##1 i_fault_reg;
    endproperty
    a_defmap_xn: assert property (p_defmap_xn) else $error("default map fetch not blocked");

    property p_table_read;
        @(posedge pclk) disable iff (!presetn)
        d_valid && (d_excl_status || d_table_branch) |-> d_fwd_read;
    endproperty
    a_table_read: assert property (p_table_read) else $error("status or table read not a read");

    property p_so_complete;
        @(posedge pclk) disable iff (!presetn)
        so_pend_reg && !m_side_effect_ready |-> !d_complete;
    endproperty
    a_so_complete: assert property (p_so_complete) else $error("completion before side effects");

    property p_sticky;
        @(posedge pclk) disable iff (!presetn)
        status_reg[PAC_ST_DFAULT] && !(wr_en && status_sel && pwdata[PAC_ST_DFAULT]) |=> status_reg[PAC_ST_DFAULT];
    endproperty
    a_sticky: assert property (p_sticky) else $error("fault status lost");

    property p_so_set;
        @(posedge pclk) disable iff (!presetn)
        d_fwd_ordered |=> so_pend_reg;
    endproperty
    a_so_set: assert property (p_so_set) else $error("ordered access not held pending");

    property p_fault_addr;
        @(posedge pclk) disable iff (!presetn)
        d_valid && prot_en && !d_rights |=> faddr_reg == $past(d_addr);
    endproperty
    a_fault_addr: assert property (p_fault_addr) else $error("fault address not recorded");

    property p_excl_any;
        @(posedge pclk) disable iff (!presetn)
        d_valid && d_exclusive && d_allow |-> d_fwd_valid && (d_fwd_excl_shared == (d_any && d_attr[PAC_AT_SH]));
    endproperty
    a_excl_any: assert property (p_excl_any) else $error("exclusive access mishandled");
endmodule

// file: tb/pac_mem_model.sv
`timescale 1ns/1ns
// ==================== memory side: observes a forwarded access after 1 or 3 cycles
module pac_mem_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic d_fwd_valid,
    input wire logic slow,
    output logic m_observed,
    output logic m_fetch_observed,
    output logic m_side_effect_ready
);
    logic [1:0] cnt_reg;
    logic se_reg;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_reg <= 2'h0;
            se_reg <= 1'b0;
        end else begin
            cnt_reg <= d_fwd_valid ? (slow ? 2'h3 : 2'h1) : (cnt_reg != 2'h0 ? cnt_reg - 2'h1 : 2'h0);
            se_reg <= m_observed;
        end
    end
    // observation is a one-cycle event, so a late side effect can miss it
    assign m_observed = cnt_reg == 2'h1;
    assign m_fetch_observed = cnt_reg == 2'h1;
    assign m_side_effect_ready = slow ? se_reg : m_observed;
endmodule

// file: tb/pac_checker_bench.sv
`timescale 1ns/1ns
module pac_checker_bench;
    import pac_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err, slow, chk_on;
    logic [PAC_AW-1:0] paddr;
    logic [31:0] pwdata, prdata, d_addr, i_addr, rd, faddr;
    logic [31:0] rbase[4], rlim[4];
    logic d_valid, d_write, d_priv_exec, d_mode_unpriv_only, d_unpriv_variant, d_excl_status;
    logic d_table_branch, d_exclusive, d_fwd_valid, d_fwd_read, d_fwd_excl_shared, d_fwd_ordered;
    logic i_valid, i_priv, i_fwd_valid, m_observed, m_fetch_observed, m_side_effect_ready;
    logic d_complete, memory_management_fault, ord_exp, cmp_exp, so_pend, deny_prev;
    int bad_count, tests_run, cycles, rattr[4], ctrl, st, h;
    bit unp, rdacc, dok, iok, on;
    pac_checker uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .d_valid(d_valid), .d_addr(d_addr), .d_write(d_write), .d_priv_exec(d_priv_exec),
        .d_mode_unpriv_only(d_mode_unpriv_only), .d_unpriv_variant(d_unpriv_variant),
        .d_excl_status(d_excl_status), .d_table_branch(d_table_branch), .d_exclusive(d_exclusive),
        .d_fwd_valid(d_fwd_valid), .d_fwd_read(d_fwd_read), .d_fwd_excl_shared(d_fwd_excl_shared),
        .d_fwd_ordered(d_fwd_ordered), .i_valid(i_valid), .i_addr(i_addr), .i_priv(i_priv),
        .i_fwd_valid(i_fwd_valid), .m_observed(m_observed), .m_fetch_observed(m_fetch_observed),
        .m_side_effect_ready(m_side_effect_ready), .d_complete(d_complete),
        .memory_management_fault(memory_management_fault));
    pac_mem_model mem (.pclk(pclk), .presetn(presetn), .d_fwd_valid(d_fwd_valid), .slow(slow),
        .m_observed(m_observed), .m_fetch_observed(m_fetch_observed), .m_side_effect_ready(m_side_effect_ready));
    // ==================== reference model
    function automatic bit permit(logic [1:0] lvl, bit u);
        return lvl == PAC_LVL_ALL || (lvl == PAC_LVL_PRIV && !u);
    endfunction
    function automatic int hit(logic [31:0] a);
        int r = -1;
        for (int n = 0; n < 4; n++) if (rattr[n][PAC_AT_EN] && a >= rbase[n] && a <= rlim[n]) r = n;
        return r;
    endfunction
    function automatic bit d_ok(logic [31:0] a, bit u, bit rdx);
        int r = hit(a);
        if (!ctrl[0]) return 1;
        if (r < 0) return !u;
        return permit(rdx ? rattr[r][1:0] : rattr[r][3:2], u);
    endfunction
    function automatic bit i_ok(logic [31:0] a, bit u);
        int r = hit(a);
        bit dm = ctrl[1] && a >= 32'hF000_0000;
        if (!ctrl[0] || r < 0) return !dm && (!ctrl[0] || !u);
        return !rattr[r][PAC_AT_EXEC_NEVER] && permit(rattr[r][1:0], u);
    endfunction
    task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic apb(bit wr, logic [11:0] a, logic [31:0] wd);
        @(posedge pclk);
        psel <= 1;
        penable <= 0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
    endtask
    task report_and_stop;
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // ==================== per-cycle comparison, settled at the falling edge
    always @(negedge pclk) begin
        unp = d_mode_unpriv_only | d_unpriv_variant | ~d_priv_exec;
        rdacc = ~d_write | d_excl_status | d_table_branch;
        dok = d_ok(d_addr, unp, rdacc);
        iok = i_ok(i_addr, ~i_priv);
        h = hit(d_addr) < 0 ? 0 : hit(d_addr);
        // region attributes mark forwarded accesses even while protection is off
        on = hit(d_addr) >= 0 && d_valid && dok;
        ord_exp = on && rattr[h][PAC_AT_SO];
        cmp_exp = m_observed & m_fetch_observed & (~so_pend | m_side_effect_ready);
        if (chk_on) begin
            chk("fwd", d_fwd_valid, d_valid & dok);
            chk("read", d_fwd_read, rdacc);
            chk("excl", d_fwd_excl_shared, d_exclusive && hit(d_addr) >= 0 && rattr[h][PAC_AT_SH]);
            chk("ord", d_fwd_ordered, ord_exp);
            chk("ifwd", i_fwd_valid, i_valid & iok);
            chk("fault", memory_management_fault, deny_prev);
            chk("cmpl", d_complete, cmp_exp);
            if (i_valid && !iok) begin
                st |= 2;
                faddr = i_addr;
            end
            if (d_valid && !dok) begin
                st |= unp ? 5 : 1;
                faddr = d_addr;
            end
        end
        deny_prev = chk_on && ((d_valid && !dok) || (i_valid && !iok));
    end
    always @(posedge pclk) begin
        so_pend <= !presetn ? 1'b0 : (ord_exp ? 1'b1 : (cmp_exp ? 1'b0 : so_pend));
        cycles++;
        if (cycles == 6000) begin
            bad_count++;
            report_and_stop;
        end
    end
    initial begin
        pclk = 0;
        forever #20 pclk = ~pclk;
    end
    // ==================== main sequence
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata, d_valid, d_addr, i_addr, slow, chk_on} = '0;
        {d_write, d_priv_exec, d_mode_unpriv_only, d_unpriv_variant, d_excl_status} = '0;
        {d_table_branch, d_exclusive, i_valid, i_priv, so_pend, deny_prev} = '0;
        {bad_count, tests_run, cycles, ctrl, st, faddr} = '0;
        rd = $urandom(44530);
        repeat (4) @(posedge pclk);
        presetn <= 1;
        foreach (rattr[n]) rattr[n] = 0;
        apb(0, PAC_CTRL_OFF, 0);
        chk("ctrl", rd, 0);
        apb(0, PAC_STATUS_OFF, 0);
        chk("status", rd, 0);
        apb(1, PAC_FADDR_OFF, 32'h0000_0123); // read-only: write ignored
        apb(0, PAC_FADDR_OFF, 0);
        chk("faddr", rd, 0);
        apb(0, 12'h00C, 0);
        chk("unmapped", {err, rd[30:0]}, 32'h8000_0000);
        $display("register reset test done");
        for (int c = 0; c < 4; c++) begin
            for (int n = 0; n < 4; n++) begin
                // overlapping windows so the highest region decides
                rbase[n] = 32'h100 * (n + 1);
                rlim[n] = rbase[n] + 32'h1FF;
                rattr[n] = ($urandom & 8'hFF) | (c == 3 ? 8'h20 : 8'h00);
                apb(1, 12'(16 * n + 16), rbase[n]);
                apb(1, 12'(16 * n + 20), rlim[n]);
                apb(1, 12'(16 * n + 24), rattr[n]);
                apb(0, 12'(16 * n + 24), 0);
                chk("attr", rd, rattr[n]);
            end
            ctrl = c;
            slow = c[0];
            apb(1, PAC_CTRL_OFF, c);
            chk_on = 1;
            repeat (150) begin
                @(posedge pclk);
                d_valid <= $urandom % 4 != 0;
                i_valid <= $urandom % 3 != 0;
                d_addr <= $urandom % 5 == 0 ? 32'hF000_0104 : $urandom % 32'h600;
                i_addr <= $urandom % 4 == 0 ? 32'hF000_0200 : $urandom % 32'h600;
                {d_write, d_priv_exec, d_mode_unpriv_only, d_unpriv_variant, d_excl_status,
                    d_table_branch, d_exclusive, i_priv} <= 8'($urandom);
            end
            @(posedge pclk);
            d_valid <= 0;
            i_valid <= 0;
            repeat (3) @(posedge pclk);
            chk_on = 0;
            apb(0, PAC_STATUS_OFF, 0);
            chk("status", rd, st);
            apb(0, PAC_FADDR_OFF, 0);
            chk("faddr", rd, faddr);
            apb(1, PAC_STATUS_OFF, 7);
            apb(0, PAC_STATUS_OFF, 0);
            chk("status clear", rd, 0);
            st = 0;
            $display("phase %0d test done", c);
        end
        report_and_stop;
    end
endmodule
